/* core/compare_port_control_exec.sv */
// Operation
// - acc-le-immediate sets flag when accumulator <= operand, accumulator kept.
// - memory-nonzero sets flag when RAM at row/column is nonzero.
// - column-ne-acc sets flag when column index differs from accumulator.
// - column-ne-immediate sets flag when column index differs from operand.
// - first port load gives key port for rows 0-1, P port for 2-3.
// - second port load gives R port for rows 0-1, CS port for 2-3.
// - output set drives selected bit high; 9 all P/CS, F all ports.
// - output set: 8 infrared low, A-B CS pull-up off, E transmit-key scan.
// - output clear mirrors set: clears bits, floats infrared, pull-up on, matrix scan.
// - watchdog clear resets the watchdog counter.
// - stop halts oscillator until a release event.
// - pulse-mode load copies column index into pulse mode register.
// - no-operation sets flag, changes nothing else.
module compare_port_control_exec (
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  input  wire logic              EXEC,
  input  wire cpe_pkg::op_t      OPCODE,
  input  wire logic [3:0]        OPERAND,
  input  wire logic [3:0]        ACC,
  input  wire logic [3:0]        ROW_IDX,
  input  wire logic [3:0]        COL_IDX,
  input  wire logic              RAM_WE,
  input  wire logic [3:0]        RAM_WDATA,
  input  wire logic [3:0]        KEY_IN,
  input  wire logic [3:0]        P_IN,
  input  wire logic [2:0]        R_IN,
  input  wire logic [1:0]        CS_IN,
  input  wire logic              RELEASE,
  output logic                   FLAG_BIT,
  output logic                   ACC_LOAD,
  output logic [3:0]             ACC_DATA,
  output logic [3:0]             KEY_OUT,
  output logic [3:0]             P_OUT,
  output logic [2:0]             R_OUT,
  output logic [1:0]             CS_OUT,
  output logic [1:0]             CS_PULLUP_EN,
  output logic                   INFRARED_DRIVE_PIN_OE,
  output logic                   TKEY_SCAN,
  output logic [3:0]             PULSE_MODE_REGISTER,
  output logic [cpe_pkg::WDT_W-1:0] WATCHDOG_COUNTER,
  output logic                   STOPPED
);
  logic [3:0] ram_rdata;
  logic       mem_pend_q;
  logic       row_hi;
  logic [1:0] sel2;
  logic [2:0] sel3;
  logic       set_v;
  logic       is_set;
  logic       is_clr;

  localparam logic [cpe_pkg::WDT_W-1:0] wdt_step = {{(cpe_pkg::WDT_W-1){1'b0}}, 1'b1};

  assign row_hi = ROW_IDX[cpe_pkg::ROW_SEL_BIT];
  assign sel2   = COL_IDX[1:0];
  assign sel3   = 3'(COL_IDX - cpe_pkg::COL_HIGH_FIRST);
  assign is_set = EXEC && OPCODE == cpe_pkg::OUTPUT_LATCH_SET_OP && !STOPPED;
  assign is_clr = EXEC && OPCODE == cpe_pkg::OUTPUT_LATCH_CLEAR_OP && !STOPPED;
  assign set_v  = is_set;

  // ----------------------------------------
  // data memory addressed by row and column
  // ----------------------------------------
  nibble_ram u_ram (
    .clk   (REF_CLK),
    .we    (RAM_WE),
    .addr  ({ROW_IDX[0], COL_IDX}),
    .wdata (RAM_WDATA),
    .rdata (ram_rdata)
  );

  // ----------------------------------------
  // status flag
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      FLAG_BIT   <= 1'b1;
      mem_pend_q <= 1'b0;
    end else begin
      mem_pend_q <= 1'b0;
      if (mem_pend_q) begin
        FLAG_BIT <= (ram_rdata != 4'h0);
      end else if (EXEC && !STOPPED) begin
        case (OPCODE)
          cpe_pkg::ACC_LE_IMMEDIATE_OP:    FLAG_BIT <= (ACC <= OPERAND);
          cpe_pkg::MEMORY_NONZERO_TEST_OP: mem_pend_q <= 1'b1;
          cpe_pkg::COLUMN_NE_ACC_OP:       FLAG_BIT <= (COL_IDX != ACC);
          cpe_pkg::COLUMN_NE_IMMEDIATE_OP: FLAG_BIT <= (COL_IDX != OPERAND);
          default:                         FLAG_BIT <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // accumulator load from ports
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ACC_LOAD <= 1'b0;
      ACC_DATA <= 4'h0;
    end else begin
      ACC_LOAD <= 1'b0;
      if (EXEC && !STOPPED && OPCODE == cpe_pkg::LOAD_ACC_FIRST_PORTS_OP) begin
        ACC_LOAD <= 1'b1;
        ACC_DATA <= row_hi ? P_IN : KEY_IN;
      end else if (EXEC && !STOPPED && OPCODE == cpe_pkg::LOAD_ACC_SECOND_PORTS_OP) begin
        ACC_LOAD <= 1'b1;
        ACC_DATA <= row_hi ? {2'h0, CS_IN} : {1'b0, R_IN};
      end
    end
  end

  // ----------------------------------------
  // output latches
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      KEY_OUT <= cpe_pkg::PORT4_RST;
      P_OUT   <= cpe_pkg::PORT4_RST;
      R_OUT   <= cpe_pkg::PORT3_RST;
      CS_OUT  <= cpe_pkg::PORT2_RST;
    end else if (is_set || is_clr) begin
      if (COL_IDX <= cpe_pkg::COL_BIT_LAST) begin
        if (row_hi) P_OUT[sel2] <= set_v;
        else KEY_OUT[sel2] <= set_v;
      end else if (COL_IDX <= cpe_pkg::COL_HIGH_LAST) begin
        if (row_hi) begin
          if (sel3 <= 3'h1) CS_OUT[sel3[0]] <= set_v;
        end else if (sel3 <= 3'h2) begin
          R_OUT[sel3[1:0]] <= set_v;
        end
      end else if (COL_IDX == cpe_pkg::COL_P_CS_ALL) begin
        P_OUT  <= {4{set_v}};
        CS_OUT <= {2{set_v}};
      end else if (COL_IDX == cpe_pkg::COL_ALL) begin
        KEY_OUT <= {4{set_v}};
        P_OUT   <= {4{set_v}};
        R_OUT   <= {3{set_v}};
        CS_OUT  <= {2{set_v}};
      end
    end
  end

  // ----------------------------------------
  // infrared, pull-up and scan controls
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      INFRARED_DRIVE_PIN_OE <= 1'b0;
      CS_PULLUP_EN          <= cpe_pkg::PU_RST;
      TKEY_SCAN             <= 1'b0;
    end else if (is_set || is_clr) begin
      if (COL_IDX == cpe_pkg::COL_IR) begin
        INFRARED_DRIVE_PIN_OE <= set_v;
      end
      if (COL_IDX >= cpe_pkg::COL_PU_FIRST && COL_IDX <= cpe_pkg::COL_PU_LAST) begin
        CS_PULLUP_EN[COL_IDX[0]] <= !set_v;
      end
      if (COL_IDX == cpe_pkg::COL_SCAN) begin
        TKEY_SCAN <= set_v;
      end
    end
  end

  // ----------------------------------------
  // pulse mode, watchdog, stop
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PULSE_MODE_REGISTER <= cpe_pkg::PMR_RST;
    end else if (EXEC && !STOPPED && OPCODE == cpe_pkg::PULSE_MODE_LOAD_OP) begin
      PULSE_MODE_REGISTER <= COL_IDX;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WATCHDOG_COUNTER <= '0;
    end else if (EXEC && !STOPPED && OPCODE == cpe_pkg::WATCHDOG_CLEAR_OP) begin
      WATCHDOG_COUNTER <= '0;
    end else if (!STOPPED) begin
      WATCHDOG_COUNTER <= WATCHDOG_COUNTER + wdt_step;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      STOPPED <= 1'b0;
    end else if (STOPPED && RELEASE) begin
      STOPPED <= 1'b0;
    end else if (EXEC && OPCODE == cpe_pkg::STOP_OP) begin
      STOPPED <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence exec_s(cpe_pkg::op_t op);
    EXEC && !STOPPED && OPCODE == op;
  endsequence

  acc_le_flag_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::ACC_LE_IMMEDIATE_OP) ##0 !mem_pend_q |=> FLAG_BIT == $past(ACC <= OPERAND))
    else $error("compare flag wrong");
  mem_nonzero_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::MEMORY_NONZERO_TEST_OP) ##0 !mem_pend_q ##1 1'b1 |=> FLAG_BIT == ($past(ram_rdata) != 4'h0))
    else $error("memory test flag wrong");
  col_ne_acc_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::COLUMN_NE_ACC_OP) ##0 !mem_pend_q |=> FLAG_BIT == $past(COL_IDX != ACC))
    else $error("column compare flag wrong");
  col_ne_imm_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::COLUMN_NE_IMMEDIATE_OP) ##0 !mem_pend_q |=> FLAG_BIT == $past(COL_IDX != OPERAND))
    else $error("column immediate flag wrong");
  port_load_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::LOAD_ACC_FIRST_PORTS_OP) |=> ACC_LOAD && ACC_DATA == $past(row_hi ? P_IN : KEY_IN))
    else $error("first port load wrong");
  ir_drive_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    is_set && COL_IDX == cpe_pkg::COL_IR |=> INFRARED_DRIVE_PIN_OE)
    else $error("infrared not driven");
  all_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    is_clr && COL_IDX == cpe_pkg::COL_ALL |=> KEY_OUT == 4'h0 && P_OUT == 4'h0 && R_OUT == 3'h0 && CS_OUT == 2'h0)
    else $error("ports not cleared");
  wdt_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::WATCHDOG_CLEAR_OP) |=> WATCHDOG_COUNTER == '0 ##1
      WATCHDOG_COUNTER == (($past(EXEC) && $past(OPCODE) == cpe_pkg::WATCHDOG_CLEAR_OP) ? '0 : wdt_step))
    else $error("watchdog not cleared");
  nop_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::NOP_OP) |=> !ACC_LOAD && $stable(KEY_OUT) && $stable(P_OUT) && $stable(R_OUT)
      && $stable(CS_OUT) && $stable(PULSE_MODE_REGISTER) && $stable(CS_PULLUP_EN))
    else $error("no-operation changed state");
  pulse_mode_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec_s(cpe_pkg::PULSE_MODE_LOAD_OP) |=> PULSE_MODE_REGISTER == $past(COL_IDX))
    else $error("pulse mode not loaded");
  stop_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    STOPPED && !RELEASE |=> STOPPED && $stable(WATCHDOG_COUNTER))
    else $error("stop not held");
endmodule : compare_port_control_exec

/* core/cpe_pkg.sv */
package cpe_pkg;
  // ----------------------------------------
  // instruction codes presented by the core
  // ----------------------------------------
  typedef enum logic [3:0] {
    NOP_OP, ACC_LE_IMMEDIATE_OP, MEMORY_NONZERO_TEST_OP, COLUMN_NE_ACC_OP,
    COLUMN_NE_IMMEDIATE_OP, LOAD_ACC_FIRST_PORTS_OP, LOAD_ACC_SECOND_PORTS_OP,
    OUTPUT_LATCH_SET_OP, OUTPUT_LATCH_CLEAR_OP, WATCHDOG_CLEAR_OP, STOP_OP,
    PULSE_MODE_LOAD_OP
  } op_t;

  // ----------------------------------------
  // column index decode points
  // ----------------------------------------
  localparam logic [3:0] COL_BIT_LAST   = 4'h3;
  localparam logic [3:0] COL_HIGH_FIRST = 4'h4;
  localparam logic [3:0] COL_HIGH_LAST  = 4'h7;
  localparam logic [3:0] COL_IR         = 4'h8;
  localparam logic [3:0] COL_P_CS_ALL   = 4'h9;
  localparam logic [3:0] COL_PU_FIRST   = 4'hA;
  localparam logic [3:0] COL_PU_LAST    = 4'hB;
  localparam logic [3:0] COL_SCAN       = 4'hE;
  localparam logic [3:0] COL_ALL        = 4'hF;
  localparam int         ROW_SEL_BIT    = 1;

  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [3:0] PORT4_RST  = 4'hF;
  localparam logic [2:0] PORT3_RST  = 3'h7;
  localparam logic [1:0] PORT2_RST  = 2'h3;
  localparam logic [1:0] PU_RST     = 2'h3;
  localparam logic [3:0] PMR_RST    = 4'h0;
  localparam int         WDT_W      = 12;
  localparam int         RAM_AW     = 5;
endpackage : cpe_pkg

/* core/nibble_ram.sv */
module nibble_ram (
  input  wire logic                          clk,
  input  wire logic                          we,
  input  wire logic [cpe_pkg::RAM_AW-1:0]    addr,
  input  wire logic [3:0]                    wdata,
  output logic      [3:0]                    rdata
);
  logic [3:0] mem [0:(1<<cpe_pkg::RAM_AW)-1];

  // ----------------------------------------
  // registered read, old data on a same-cycle write
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : nibble_ram

/* dv/pin_partner.sv */
module pin_partner (
  input  wire logic [3:0] key_latch,
  input  wire logic [3:0] p_latch,
  input  wire logic [2:0] r_latch,
  input  wire logic [1:0] cs_latch,
  input  wire logic [3:0] key_ext,
  input  wire logic [3:0] p_ext,
  input  wire logic [2:0] r_ext,
  input  wire logic [1:0] cs_ext,
  output logic      [3:0] key_pin,
  output logic      [2:0] r_pin,
  output logic      [3:0] p_pin,
  output logic      [1:0] cs_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // low latch sinks the pin, high leaves it to the outside
  // ----------------------------------------
  assign key_pin = key_latch & key_ext;
  assign p_pin   = p_latch & p_ext;
  assign r_pin   = r_latch & r_ext;
  assign cs_pin  = cs_latch & cs_ext;
endmodule : pin_partner

/* dv/compare_port_control_exec_bench.sv */
module compare_port_control_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // far-side pin levels stand from time zero, never changing before a read
  localparam logic [3:0] KX = 4'hA;
  localparam logic [3:0] PX = 4'h5;
  localparam logic [2:0] RX = 3'h6;
  localparam logic [1:0] CX = 2'h1;
  logic                      clk, nrst, exec, ram_we, rel, flag, acc_load, ir_oe, tkey, stopped;
  cpe_pkg::op_t              op;
  logic [3:0]                opd, acc, row, col, ram_wd, key_i, p_i, key_o, p_o, acc_data, pulse_mode_register;
  logic [2:0]                r_i, r_o;
  logic [1:0]                cs_i, cs_o, pu;
  logic [cpe_pkg::WDT_W-1:0] wdt;
  int                        fail_count, checked;
  logic [3:0]                ta [4] = '{4'h5, 4'h6, 4'h0, 4'hF};
  logic [3:0]                tb [4] = '{4'h5, 4'h5, 4'hF, 4'h0};
  logic                      tf [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  compare_port_control_exec u_compare_port_control_exec (
    .REF_CLK(clk), .NRST(nrst), .EXEC(exec), .OPCODE(op), .OPERAND(opd), .ACC(acc),
    .ROW_IDX(row), .COL_IDX(col), .RAM_WE(ram_we), .RAM_WDATA(ram_wd), .KEY_IN(key_i),
    .P_IN(p_i), .R_IN(r_i), .CS_IN(cs_i), .RELEASE(rel), .FLAG_BIT(flag), .ACC_LOAD(acc_load),
    .ACC_DATA(acc_data), .KEY_OUT(key_o), .P_OUT(p_o), .R_OUT(r_o), .CS_OUT(cs_o),
    .CS_PULLUP_EN(pu), .INFRARED_DRIVE_PIN_OE(ir_oe), .TKEY_SCAN(tkey),
    .PULSE_MODE_REGISTER(pulse_mode_register), .WATCHDOG_COUNTER(wdt), .STOPPED(stopped));

  pin_partner u_pin_partner (
    .key_latch(key_o), .p_latch(p_o), .r_latch(r_o), .cs_latch(cs_o), .key_ext(KX),
    .p_ext(PX), .r_ext(RX), .cs_ext(CX), .key_pin(key_i), .p_pin(p_i), .r_pin(r_i), .cs_pin(cs_i));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic ex(input cpe_pkg::op_t o, input logic [3:0] d, a, x, y);
    @(posedge clk) #1;
    op = o; opd = d; acc = a; row = x; col = y; exec = 1'b1;
    @(posedge clk) #1;
    exec = 1'b0;
  endtask : ex

  task automatic wr(input logic [3:0] x, y, d);
    @(posedge clk) #1;
    row = x; col = y; ram_wd = d; ram_we = 1'b1;
    @(posedge clk) #1;
    ram_we = 1'b0;
  endtask : wr

  task automatic final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    fail_count = 0; checked = 0; nrst = 1'b0; exec = 1'b0; op = cpe_pkg::NOP_OP; rel = 1'b0;
    opd = 4'h0; acc = 4'h0; row = 4'h0; col = 4'h0; ram_we = 1'b0; ram_wd = 4'h0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    chk({flag, ir_oe, tkey, pu, pulse_mode_register, key_o, p_o, r_o, cs_o}, {9'h130, 13'h1FFF});
    for (int i = 0; i < 4; i++) begin
      ex(cpe_pkg::ACC_LE_IMMEDIATE_OP, tb[i], ta[i], 4'h0, 4'h0);
      chk({flag, acc_load}, {tf[i], 1'b0});
    end
    ex(cpe_pkg::COLUMN_NE_ACC_OP, 4'h0, 4'h4, 4'h0, 4'h4); chk(flag, 1'b0);
    ex(cpe_pkg::COLUMN_NE_ACC_OP, 4'h0, 4'h5, 4'h0, 4'h4); chk(flag, 1'b1);
    ex(cpe_pkg::COLUMN_NE_IMMEDIATE_OP, 4'hF, 4'h0, 4'h0, 4'hF); chk(flag, 1'b0);
    ex(cpe_pkg::COLUMN_NE_IMMEDIATE_OP, 4'h9, 4'h0, 4'h0, 4'h3); chk(flag, 1'b1);
    wr(4'h1, 4'h7, 4'h0);
    wr(4'h0, 4'h7, 4'h8);
    ex(cpe_pkg::MEMORY_NONZERO_TEST_OP, 4'h0, 4'h0, 4'h1, 4'h7);
    @(posedge clk) #1 chk(flag, 1'b0);
    ex(cpe_pkg::MEMORY_NONZERO_TEST_OP, 4'h0, 4'h0, 4'h0, 4'h7);
    @(posedge clk) #1 chk(flag, 1'b1);
    for (int x = 0; x < 4; x++) begin
      ex(cpe_pkg::LOAD_ACC_FIRST_PORTS_OP, 4'h0, 4'h0, x[3:0], 4'h0);
      chk({acc_load, acc_data}, {1'b1, x < 2 ? KX : PX});
      ex(cpe_pkg::LOAD_ACC_SECOND_PORTS_OP, 4'h0, 4'h0, x[3:0], 4'h0);
      chk({acc_load, acc_data}, {1'b1, x < 2 ? {1'b0, RX} : {2'b0, CX}});
    end
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'h2);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h1, 4'h6);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h2, 4'h5);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h3, 4'h7);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'h1);
    chk({key_o, p_o, r_o, cs_o}, {4'h9, 4'hF, 3'h3, 2'h1});
    ex(cpe_pkg::LOAD_ACC_FIRST_PORTS_OP, 4'h0, 4'h0, 4'h0, 4'h0); chk(acc_data, 4'h8);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h2, 4'h9);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'h6);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h1, 4'h1);
    chk({key_o, p_o, r_o, cs_o}, {4'hB, 4'hF, 3'h7, 2'h3});
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'hF);
    chk({key_o, p_o, r_o, cs_o}, 13'h0000);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h3, 4'h2);
    chk({key_o, p_o, r_o, cs_o}, {4'h0, 4'h4, 3'h0, 2'h0});
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'hF);
    chk({key_o, p_o, r_o, cs_o}, 13'h1FFF);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'h8); chk(ir_oe, 1'b1);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'h8); chk(ir_oe, 1'b0);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'hA); chk(pu, 2'h2);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'hB); chk(pu, 2'h0);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'hB); chk(pu, 2'h2);
    ex(cpe_pkg::OUTPUT_LATCH_SET_OP, 4'h0, 4'h0, 4'h0, 4'hE); chk(tkey, 1'b1);
    ex(cpe_pkg::OUTPUT_LATCH_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'hE); chk(tkey, 1'b0);
    ex(cpe_pkg::PULSE_MODE_LOAD_OP, 4'h0, 4'h0, 4'h0, 4'h5); chk(pulse_mode_register, 4'h5);
    ex(cpe_pkg::COLUMN_NE_IMMEDIATE_OP, 4'h3, 4'h0, 4'h0, 4'h3);
    ex(cpe_pkg::NOP_OP, 4'h0, 4'h0, 4'h0, 4'h0);
    chk({flag, pulse_mode_register, key_o, p_o, r_o, cs_o, pu}, {1'b1, 4'h5, 13'h1FFF, 2'h2});
    repeat (20) @(posedge clk);
    chk(wdt > 12'h00A, 1'b1);
    ex(cpe_pkg::WATCHDOG_CLEAR_OP, 4'h0, 4'h0, 4'h0, 4'h0); chk(wdt, '0);
    ex(cpe_pkg::STOP_OP, 4'h0, 4'h0, 4'h0, 4'h0); chk(stopped, 1'b1);
    ex(cpe_pkg::NOP_OP, 4'h0, 4'h0, 4'h0, 4'h0);
    ex(cpe_pkg::PULSE_MODE_LOAD_OP, 4'h0, 4'h0, 4'h0, 4'h9); chk(pulse_mode_register, 4'h5);
    @(posedge clk) #1 rel = 1'b1;
    @(posedge clk) #1 rel = 1'b0;
    chk(stopped, 1'b0);
    ex(cpe_pkg::NOP_OP, 4'h0, 4'h0, 4'h0, 4'h0); chk(stopped, 1'b0);
    final_report;
  end

  initial begin
    #50000;
    fail_count++;
    final_report;
  end
endmodule : compare_port_control_exec_bench
